// [design/diag_regs.svh]
// Purpose: register indices, field positions, reset values and counts
// Assumes: 32-bit APB words; byte address is four times the index
// Notes: definitions only
`ifndef DIAG_REGS_SVH
`define DIAG_REGS_SVH
// ==========================================
// register indices (paddr[7:2])
`define IDX_ISR1 6'h12
`define IDX_FCC 6'h14
`define IDX_REC 6'h15
`define IDX_CTRL 6'h16
// ==========================================
// control field positions
`define CT_MODE 14
`define CT_CHK 13
`define CT_GEN 12
`define CT_LOCK 11
`define CT_LOSS 10
`define CT_GST 9
`define CT_PWR 8
`define CT_TXLB 6
`define CT_LB_HI 4
// interrupt register field positions
`define IS_FC_PEND 9
`define IS_RE_PEND 8
`define IS_FC_EN 1
`define IS_RE_EN 0
// ==========================================
// counts and codes
`define FC_MAX 8'hff
`define HF_LVL 8'h7f
`define REC_MAX 16'hffff
`define REC_HF 16'h007f
`define BE_MAX 8'hff
`define LOCK_CNT 5'h10
`define LOSS_CNT 4'h8
`define PRBS_SEED 15'h7fff
`define LB_PCS_IN 5'h01
`define LB_PCS_OUT 5'h02
`define LB_DIG 5'h04
`define LB_ANA 5'h08
`define LB_REV 5'h10
`endif

// [design/diag_pkg.sv]
// Purpose: shared types of the diagnostic block
// Assumes: nothing
// Notes: constants live in diag_regs.svh
package diag_pkg;
  // ==========================================
  // checker states
  typedef enum logic [0:0] {
    ST_HUNT,
    ST_LOCKED
  } chk_state_e;
  // decoded loopback points, one hot or none
  typedef struct packed {
    logic pcs_in;
    logic pcs_out;
    logic digital;
    logic analog;
    logic reverse;
  } lb_sel_s;
  // receive status from the phy core
  typedef struct packed {
    logic false_carrier;
    logic rx_err;
    logic rx_dv;
    logic carrier_ok;
  } rx_stat_s;
endpackage

// [design/phy_diag_counters_bist_loopback.sv]
// Purpose: diagnostic counters, prbs self test and loopback control
// Assumes: all status inputs are on clk_sys; apb slave, zero wait
// Notes: read data is sampled in the setup phase
//
// Design decision made here: the APB register port.
`timescale 1ns/10ps
`include "diag_regs.svh"
module phy_diag_counters_bist_loopback (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire diag_pkg::rx_stat_s rx_stat,
  input wire logic mii_loopback,
  input wire logic speed_100,
  input wire logic sleep_mode,
  input wire logic chk_rx_bit,
  input wire logic chk_rx_valid,
  input wire logic [3:0] mac_txd,
  input wire logic mac_tx_en,
  output logic [3:0] line_txd,
  output logic line_tx_en,
  output logic gen_tx_bit,
  output diag_pkg::lb_sel_s lb_sel,
  output logic [7:0] bist_err_count,
  output logic bist_err_pulse,
  output logic diag_irq
);
  import diag_pkg::*;

  // ==========================================
  // helpers
  // next prbs15 state, x^15 + x^14 + 1
  function automatic logic [14:0] prbs_next(input logic [14:0] s, input logic b);
    prbs_next = {s[13:0], b};
  endfunction
  // prbs feedback bit of a state
  function automatic logic prbs_fb(input logic [14:0] s);
    prbs_fb = s[14] ^ s[13];
  endfunction

  // ==========================================
  // state
  logic [7:0] fc_cnt_ff; // false carrier count
  logic [15:0] rec_cnt_ff; // receive error count
  logic [7:0] snap_ff; // false carrier value read
  logic [15:0] snap_rec_ff; // receive error value read
  logic [15:0] ctrl_ff; // control rw bits
  logic fc_pend_ff; // false carrier half-full pending
  logic re_pend_ff; // receive error half-full pending
  logic [1:0] int_en_ff; // half-full enables
  logic loss_ff; // latched sync loss
  logic [31:0] prdata_ff; // read data
  logic [14:0] gen_lfsr_ff; // generator state
  logic gen_act_ff; // generator running
  logic [14:0] hist_ff; // received bit history
  chk_state_e chk_st_ff; // checker state
  logic [4:0] match_ff; // consecutive matches
  logic [3:0] miss_ff; // consecutive misses
  logic [7:0] be_cnt_ff; // bist error count
  logic be_pulse_ff; // wrap pulse
  logic [3:0] txd_ff; // line data
  logic tx_en_ff; // line enable
  logic irq_ff; // interrupt level
  logic gen_bit_ff; // generator output bit

  // bus decode
  logic setup_rd, acc, acc_wr, hit;
  logic rd_fcc, rd_rec, rd_ctrl, rd_isr;
  logic [5:0] idx;
  // event decode
  logic fc_inc, re_inc, fc_hf, re_hf;
  logic chk_match, chk_err, loss_now, line_ok;
  logic [31:0] rd_mux;

  assign idx = paddr[7:2];
  assign hit = (idx == `IDX_FCC) || (idx == `IDX_REC) ||
               (idx == `IDX_CTRL) || (idx == `IDX_ISR1);
  assign setup_rd = psel && !penable && !pwrite;
  // access phase completes in one cycle while enabled
  assign acc = psel && penable && clk_en;
  assign acc_wr = acc && pwrite && hit;
  assign rd_fcc = acc && !pwrite && (idx == `IDX_FCC);
  assign rd_rec = acc && !pwrite && (idx == `IDX_REC);
  assign rd_ctrl = acc && !pwrite && (idx == `IDX_CTRL);
  assign rd_isr = acc && !pwrite && (idx == `IDX_ISR1);
  assign pready = acc;
  assign pslverr = acc && !hit;
  assign prdata = prdata_ff;

  // counted events
  assign fc_inc = rx_stat.false_carrier;
  assign re_inc = rx_stat.rx_err && rx_stat.rx_dv && rx_stat.carrier_ok &&
                  !mii_loopback;
  // crossing of the half-full level
  assign fc_hf = fc_inc && (fc_cnt_ff == `HF_LVL);
  assign re_hf = re_inc && (rec_cnt_ff == `REC_HF);

  // checker compare
  assign chk_match = chk_rx_bit == prbs_fb(hist_ff);
  assign chk_err = ctrl_ff[`CT_CHK] && chk_rx_valid && (chk_st_ff == ST_LOCKED) &&
                   !chk_match;
  assign loss_now = chk_err && (miss_ff == `LOSS_CNT - 4'h1);

  // line transmit allowed unless looped without forwarding
  assign line_ok = !mii_loopback || (speed_100 && ctrl_ff[`CT_TXLB]);

  // read mux
  always_comb begin
    rd_mux = 32'h0;
    unique case (idx)
      `IDX_FCC: rd_mux[7:0] = fc_cnt_ff;
      `IDX_REC: rd_mux[15:0] = rec_cnt_ff;
      `IDX_CTRL: begin
        rd_mux[15:0] = ctrl_ff;
        rd_mux[`CT_LOCK] = chk_st_ff == ST_LOCKED;
        rd_mux[`CT_LOSS] = loss_ff;
        rd_mux[`CT_GST] = gen_act_ff;
        rd_mux[`CT_PWR] = !sleep_mode;
      end
      `IDX_ISR1: begin
        rd_mux[`IS_FC_PEND] = fc_pend_ff;
        rd_mux[`IS_RE_PEND] = re_pend_ff;
        rd_mux[`IS_FC_EN] = int_en_ff[1];
        rd_mux[`IS_RE_EN] = int_en_ff[0];
      end
      default: rd_mux = 32'h0;
    endcase
  end

  // ==========================================
  // bus slave
  // capture read data and the counts it shows
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      prdata_ff <= 32'h0;
      snap_ff <= 8'h0;
      snap_rec_ff <= 16'h0;
    end else if (clk_en && setup_rd) begin
      prdata_ff <= rd_mux;
      snap_ff <= fc_cnt_ff;
      snap_rec_ff <= rec_cnt_ff;
    end
  end

  // control and enable writes
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      ctrl_ff <= 16'h0;
      int_en_ff <= 2'h0;
    end else if (acc_wr && idx == `IDX_CTRL) begin
      // only rw fields stored
      ctrl_ff <= '0;
      ctrl_ff[`CT_MODE] <= pwdata[`CT_MODE];
      ctrl_ff[`CT_CHK] <= pwdata[`CT_CHK];
      ctrl_ff[`CT_GEN] <= pwdata[`CT_GEN];
      ctrl_ff[`CT_TXLB] <= pwdata[`CT_TXLB];
      ctrl_ff[`CT_LB_HI:0] <= pwdata[`CT_LB_HI:0];
    end else if (acc_wr && idx == `IDX_ISR1) begin
      int_en_ff <= {pwdata[`IS_FC_EN], pwdata[`IS_RE_EN]};
    end
  end

  // ==========================================
  // counters
  // false carrier: saturate, read removes what was shown
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      fc_cnt_ff <= 8'h0;
    end else if (clk_en) begin
      if (rd_fcc) begin
        fc_cnt_ff <= fc_cnt_ff - snap_ff + {7'h0, fc_inc};
      end else if (fc_inc && fc_cnt_ff != `FC_MAX) begin
        fc_cnt_ff <= fc_cnt_ff + 8'h1;
      end
    end
  end

  // receive errors: saturate, read removes what was shown
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      rec_cnt_ff <= 16'h0;
    end else if (clk_en) begin
      if (rd_rec) begin
        rec_cnt_ff <= rec_cnt_ff - snap_rec_ff + {15'h0, re_inc};
      end else if (re_inc && rec_cnt_ff != `REC_MAX) begin
        rec_cnt_ff <= rec_cnt_ff + 16'h1;
      end
    end
  end

  // half-full pending bits, set wins over read clear
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      fc_pend_ff <= 1'b0;
      re_pend_ff <= 1'b0;
    end else if (clk_en) begin
      if (fc_hf) begin
        fc_pend_ff <= 1'b1;
      end else if (rd_isr && prdata_ff[`IS_FC_PEND]) begin
        fc_pend_ff <= 1'b0;
      end
      if (re_hf) begin
        re_pend_ff <= 1'b1;
      end else if (rd_isr && prdata_ff[`IS_RE_PEND]) begin
        re_pend_ff <= 1'b0;
      end
    end
  end

  // interrupt level from enabled pending bits
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      irq_ff <= 1'b0;
    end else if (clk_en) begin
      irq_ff <= (fc_pend_ff && int_en_ff[1]) || (re_pend_ff && int_en_ff[0]);
    end
  end
  assign diag_irq = irq_ff;

  // ==========================================
  // prbs generator
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      gen_lfsr_ff <= `PRBS_SEED;
      gen_act_ff <= 1'b0;
      gen_bit_ff <= 1'b0;
    end else if (clk_en) begin
      gen_act_ff <= ctrl_ff[`CT_GEN];
      if (ctrl_ff[`CT_GEN]) begin
        gen_lfsr_ff <= prbs_next(gen_lfsr_ff, prbs_fb(gen_lfsr_ff));
        gen_bit_ff <= prbs_fb(gen_lfsr_ff);
      end else begin
        gen_bit_ff <= 1'b0;
      end
    end
  end
  assign gen_tx_bit = gen_bit_ff;

  // ==========================================
  // prbs checker, self-synchronising on received history
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      hist_ff <= 15'h0;
      chk_st_ff <= ST_HUNT;
      match_ff <= 5'h0;
      miss_ff <= 4'h0;
    end else if (clk_en) begin
      if (!ctrl_ff[`CT_CHK]) begin
        // disabled: drop lock
        chk_st_ff <= ST_HUNT;
        match_ff <= 5'h0;
        miss_ff <= 4'h0;
      end else if (chk_rx_valid) begin
        hist_ff <= prbs_next(hist_ff, chk_rx_bit);
        unique case (chk_st_ff)
          ST_HUNT: begin
            if (!chk_match) begin
              match_ff <= 5'h0;
            end else if (match_ff == `LOCK_CNT - 5'h1) begin
              chk_st_ff <= ST_LOCKED;
              miss_ff <= 4'h0;
            end else begin
              match_ff <= match_ff + 5'h1;
            end
          end
          ST_LOCKED: begin
            if (chk_match) begin
              miss_ff <= 4'h0;
            end else if (loss_now) begin
              chk_st_ff <= ST_HUNT;
              match_ff <= 5'h0;
            end else begin
              miss_ff <= miss_ff + 4'h1;
            end
          end
        endcase
      end
    end
  end

  // sync loss latch, set wins over read clear
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      loss_ff <= 1'b0;
    end else if (clk_en) begin
      if (loss_now) begin
        loss_ff <= 1'b1;
      end else if (rd_ctrl && prdata_ff[`CT_LOSS] && chk_st_ff == ST_LOCKED) begin
        loss_ff <= 1'b0;
      end else if (rd_ctrl && prdata_ff[`CT_LOSS] && !ctrl_ff[`CT_CHK]) begin
        loss_ff <= 1'b0;
      end
    end
  end

  // bist error counter, continuous or single
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      be_cnt_ff <= 8'h0;
      be_pulse_ff <= 1'b0;
    end else if (clk_en) begin
      be_pulse_ff <= 1'b0;
      if (chk_err && be_cnt_ff == `BE_MAX) begin
        if (ctrl_ff[`CT_MODE]) begin
          be_cnt_ff <= 8'h0;
          be_pulse_ff <= 1'b1;
        end
      end else if (chk_err) begin
        be_cnt_ff <= be_cnt_ff + 8'h1;
      end
    end
  end
  assign bist_err_count = be_cnt_ff;
  assign bist_err_pulse = be_pulse_ff;

  // ==========================================
  // loopback and line path
  // loopback point decode; other codes select none
  always_comb begin
    lb_sel = '0;
    lb_sel.pcs_in = ctrl_ff[`CT_LB_HI:0] == `LB_PCS_IN;
    lb_sel.pcs_out = ctrl_ff[`CT_LB_HI:0] == `LB_PCS_OUT;
    lb_sel.digital = ctrl_ff[`CT_LB_HI:0] == `LB_DIG;
    lb_sel.analog = ctrl_ff[`CT_LB_HI:0] == `LB_ANA;
    lb_sel.reverse = ctrl_ff[`CT_LB_HI:0] == `LB_REV;
  end

  // line data only when not looped, or forwarding allowed
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      txd_ff <= 4'h0;
      tx_en_ff <= 1'b0;
    end else if (clk_en) begin
      tx_en_ff <= mac_tx_en && line_ok;
      txd_ff <= line_ok ? mac_txd : 4'h0;
    end
  end
  assign line_txd = txd_ff;
  assign line_tx_en = tx_en_ff;

  // ==========================================
  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  AST_FC_SAT: assert property (clk_en && !rd_fcc && fc_cnt_ff == `FC_MAX |=>
    fc_cnt_ff == `FC_MAX) else $error("false carrier count left max");
  AST_FC_INC: assert property (clk_en && fc_inc && !rd_fcc && fc_cnt_ff != `FC_MAX |=>
    fc_cnt_ff == $past(fc_cnt_ff) + 8'h1) else $error("false carrier missed");
  AST_FC_PEND: assert property (clk_en && fc_hf |=> fc_pend_ff)
    else $error("false carrier half-full lost");
  AST_REC_LB: assert property (clk_en && mii_loopback && !rd_rec |=>
    $stable(rec_cnt_ff)) else $error("counted in loopback");
  AST_REC_SAT: assert property (clk_en && !rd_rec && rec_cnt_ff == `REC_MAX |=>
    rec_cnt_ff == `REC_MAX) else $error("receive count wrapped");
  AST_RE_PEND: assert property (clk_en && re_hf |=> re_pend_ff && rec_cnt_ff != 16'h0)
    else $error("receive half-full lost");
  AST_IRQ: assert property (clk_en && re_pend_ff && int_en_ff[0] |=> diag_irq)
    else $error("irq not raised");
  AST_BE_SINGLE: assert property (clk_en && !ctrl_ff[`CT_MODE] && be_cnt_ff == `BE_MAX
    |=> be_cnt_ff == `BE_MAX && !bist_err_pulse) else $error("single mode moved");
  AST_LOSS: assert property (clk_en && loss_now |=> loss_ff && chk_st_ff == ST_HUNT)
    else $error("sync loss not latched");
  AST_CHK_OFF: assert property (clk_en && !ctrl_ff[`CT_CHK] |=> chk_st_ff == ST_HUNT)
    else $error("checker locked while off");
  AST_LINE: assert property (clk_en && mii_loopback && !ctrl_ff[`CT_TXLB] |=>
    !line_tx_en) else $error("line driven in loopback");
  AST_GEN: assert property (clk_en && !ctrl_ff[`CT_GEN] |=> !gen_act_ff)
    else $error("generator status stuck");
  AST_LB: assert property ($onehot0(lb_sel)) else $error("two loopback points");

  COV_FC_HF: cover property (fc_hf);
  COV_LOCK: cover property (chk_st_ff == ST_HUNT ##1 chk_st_ff == ST_LOCKED);
  COV_WRAP: cover property (bist_err_pulse);
  COV_RD_CLR: cover property (rd_rec && rec_cnt_ff != 16'h0);
endmodule

// [verification/far_end_model.sv]
// Purpose: far side of the block: mac transmit source and prbs return path
// Assumes: one clock, synchronous active-low reset
// Notes: returns the generator bit one cycle later, optionally inverted
`timescale 1ns/10ps
module far_end_model (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic gen_bit,
  input wire logic loop_on,
  input wire logic flip,
  input wire logic tx_on,
  output logic rx_bit,
  output logic rx_valid,
  output logic [3:0] txd,
  output logic tx_en
);
  // ==========================================
  // prbs return path; outside use the bit toggles so no stale value lingers
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      rx_bit <= 1'b0;
      rx_valid <= 1'b0;
    end else begin
      rx_valid <= loop_on;
      rx_bit <= loop_on ? (gen_bit ^ flip) : ~rx_bit;
    end
  end
  // ==========================================
  // mac transmit nibbles, a counting pattern while sending
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      txd <= 4'h0;
      tx_en <= 1'b0;
    end else begin
      tx_en <= tx_on;
      txd <= tx_on ? txd + 4'h1 : ~txd;
    end
  end
endmodule

// [verification/tb_top.sv]
// Purpose: self-checking bench of the diagnostic block
// Assumes: zero-wait apb slave, 100 MHz clock
// Notes: every scenario is its own task
`timescale 1ns/10ps
`include "diag_regs.svh"
module tb_top;
  import diag_pkg::*;
  // ==========================================
  // stimulus and observation signals
  logic clk_sys = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rdv;
  logic pready, pslverr, erv, pulse_seen;
  rx_stat_s rx_stat = '0;
  logic mii_loopback = 0, speed_100 = 1, sleep_mode = 0, flip = 0, tx_on = 0, loop_on = 0;
  logic clk_en = 1; // clock enable, dropped by the freeze scenario
  logic chk_rx_bit, chk_rx_valid, mac_tx_en, line_tx_en, gen_tx_bit, bist_err_pulse, diag_irq;
  logic [3:0] mac_txd, line_txd, t;
  lb_sel_s lb_sel;
  logic [7:0] bist_err_count;
  int errors = 0, total_checks = 0;
  always #5 clk_sys = ~clk_sys;
  // ==========================================
  // design and far side
  phy_diag_counters_bist_loopback u_phy_diag_counters_bist_loopback (.clk_sys(clk_sys),
    .resetn(resetn), .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rx_stat(rx_stat), .mii_loopback(mii_loopback), .speed_100(speed_100),
    .sleep_mode(sleep_mode), .chk_rx_bit(chk_rx_bit), .chk_rx_valid(chk_rx_valid),
    .mac_txd(mac_txd), .mac_tx_en(mac_tx_en), .line_txd(line_txd), .line_tx_en(line_tx_en),
    .gen_tx_bit(gen_tx_bit), .lb_sel(lb_sel), .bist_err_count(bist_err_count),
    .bist_err_pulse(bist_err_pulse), .diag_irq(diag_irq));
  far_end_model u_far_end_model (.clk_sys(clk_sys), .resetn(resetn), .gen_bit(gen_tx_bit),
    .loop_on(loop_on), .flip(flip), .tx_on(tx_on), .rx_bit(chk_rx_bit),
    .rx_valid(chk_rx_valid), .txd(mac_txd), .tx_en(mac_tx_en));
  // ==========================================
  // shared tasks
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // one apb transfer; holds the request until pready is seen high
  task automatic apb(input logic wr, input logic [5:0] idx, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clk_sys);
    psel <= 1; penable <= 0; pwrite <= wr; paddr <= {idx, 2'b00}; pwdata <= wd;
    @(posedge clk_sys);
    penable <= 1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rdv = prdata;
    erv = pslverr;
    psel <= 0; penable <= 0;
    if (n >= 50) check("pready", 0, 1);
  endtask
  task automatic rx_run(input logic [3:0] s, input int n);
    @(posedge clk_sys);
    rx_stat <= rx_stat_s'(s);
    repeat (n) @(posedge clk_sys);
    rx_stat <= '0;
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  // sparse single-bit errors, watching the wrap pulse
  task automatic inject(input int n);
    repeat (n) begin
      @(posedge clk_sys);
      flip <= 1;
      @(posedge clk_sys);
      flip <= 0;
      repeat (6) begin
        @(posedge clk_sys);
        if (bist_err_pulse === 1'b1) pulse_seen = 1;
      end
    end
  endtask
  // ==========================================
  // scenarios
  task automatic t_reset;
    apb(0, `IDX_FCC, 0); check("fcc reset", rdv, 32'h0);
    apb(0, `IDX_REC, 0); check("rec reset", rdv, 32'h0);
    apb(0, `IDX_CTRL, 0); check("ctrl reset", rdv, 32'h0000_0100);
    apb(0, `IDX_ISR1, 0); check("isr reset", rdv, 32'h0);
    apb(0, 6'h17, 0); check("unmapped err", erv, 1'b1);
    apb(1, `IDX_FCC, 32'h55); apb(0, `IDX_FCC, 0); check("fcc ro", rdv, 32'h0);
    check("lb_sel reset", lb_sel, 5'h00);
    $display("test reset done");
  endtask
  task automatic t_false_carrier;
    rx_run(4'h8, 8'h7f); apb(0, `IDX_ISR1, 0);
    check("fc hf at 7f", rdv[`IS_FC_PEND], 1'b0);
    rx_run(4'h8, 1); wait_n(3);
    check("fc irq masked", diag_irq, 1'b0);
    apb(1, `IDX_ISR1, 32'h2); wait_n(3);
    check("fc irq enabled", diag_irq, 1'b1);
    apb(0, `IDX_ISR1, 0); check("fc hf pend", rdv[`IS_FC_PEND], 1'b1);
    wait_n(3); check("fc irq cleared", diag_irq, 1'b0);
    apb(0, `IDX_FCC, 0); check("fcc 80", rdv, 32'h80);
    rx_run(4'h8, 16'h110); apb(0, `IDX_FCC, 0); check("fcc sat", rdv, 32'hff);
    apb(0, `IDX_FCC, 0); check("fcc cor", rdv, 32'h0);
    // the second climb past half-full sets pending again; read it away
    apb(0, `IDX_ISR1, 0); check("fc hf again", rdv[`IS_FC_PEND], 1'b1);
    apb(1, `IDX_ISR1, 32'h0);
    $display("test false carrier done");
  endtask
  task automatic t_rx_error;
    logic [4:0] tab [5];
    tab = '{5'h07, 5'h06, 5'h05, 5'h03, 5'h17};
    foreach (tab[i]) begin
      @(posedge clk_sys) mii_loopback <= tab[i][4];
      rx_run(tab[i][3:0], 10);
    end
    @(posedge clk_sys) mii_loopback <= 0;
    apb(0, `IDX_REC, 0); check("rec qualified", rdv, 32'd10);
    apb(1, `IDX_ISR1, 32'h1); rx_run(4'h7, 8'h80); wait_n(3);
    check("re irq", diag_irq, 1'b1);
    apb(0, `IDX_ISR1, 0); check("re pend", rdv[9:8], 2'b01);
    apb(0, `IDX_REC, 0); check("rec 80", rdv, 32'h80);
    apb(0, `IDX_REC, 0); check("rec cor", rdv, 32'h0);
    apb(1, `IDX_ISR1, 32'h0);
    $display("test receive error done");
  endtask
  task automatic t_loopback_sel;
    logic [4:0] c;
    for (int i = 0; i < 6; i++) begin
      c = (i == 5) ? 5'h00 : 5'h01 << i;
      apb(1, `IDX_CTRL, {27'h0, c});
      // the write lands at the access edge; look one edge later
      @(posedge clk_sys);
      check("lb_sel", lb_sel, {c[0], c[1], c[2], c[3], c[4]});
      apb(0, `IDX_CTRL, 0); check("lb field", rdv[4:0], c);
    end
    $display("test loopback select done");
  endtask
  task automatic t_line;
    logic [2:0] tab [4];
    logic e;
    tab = '{3'b010, 3'b110, 3'b101, 3'b111};
    @(posedge clk_sys) tx_on <= 1;
    foreach (tab[i]) begin
      @(posedge clk_sys);
      mii_loopback <= tab[i][2];
      speed_100 <= tab[i][1];
      apb(1, `IDX_CTRL, {25'h0, tab[i][0], 6'h0});
      wait_n(3);
      e = !tab[i][2] || (tab[i][1] && tab[i][0]);
      check("line_tx_en", line_tx_en, e);
      @(posedge clk_sys) t = mac_txd;
      @(posedge clk_sys);
      if (e) check("line_txd", line_txd, t);
    end
    apb(1, `IDX_CTRL, 0);
    @(posedge clk_sys);
    mii_loopback <= 0;
    speed_100 <= 1;
    tx_on <= 0;
    $display("test line forwarding done");
  endtask
  task automatic t_prbs;
    @(posedge clk_sys) loop_on <= 1;
    apb(1, `IDX_CTRL, 32'h1000); wait_n(40);
    apb(0, `IDX_CTRL, 0); check("gen only", rdv & 32'h3f00, 32'h1300);
    apb(1, `IDX_CTRL, 32'h3000); wait_n(40);
    apb(0, `IDX_CTRL, 0); check("locked", rdv & 32'h3f00, 32'h3b00);
    @(posedge clk_sys) flip <= 1;
    wait_n(20);
    flip <= 0;
    apb(0, `IDX_CTRL, 0); check("sync lost", rdv[11:10], 2'b01);
    wait_n(40);
    apb(0, `IDX_CTRL, 0); check("loss held", rdv[11:10], 2'b11);
    apb(0, `IDX_CTRL, 0); check("loss cleared", rdv[11:10], 2'b10);
    pulse_seen = 0;
    inject(120); check("single stop", bist_err_count, 8'hff);
    check("single no pulse", pulse_seen, 1'b0);
    apb(1, `IDX_CTRL, 32'h7000); inject(10);
    check("cont pulse", pulse_seen, 1'b1);
    apb(1, `IDX_CTRL, 32'h0); wait_n(3);
    repeat (3) begin
      @(posedge clk_sys);
      check("gen off bit", gen_tx_bit, 1'b0);
    end
    apb(0, `IDX_CTRL, 0); check("gen off", rdv & 32'h3f00, 32'h0100);
    @(posedge clk_sys) loop_on <= 0;
    $display("test prbs done");
  endtask
  task automatic t_sleep;
    @(posedge clk_sys) sleep_mode <= 1;
    apb(0, `IDX_CTRL, 0); check("power sleep", rdv[`CT_PWR], 1'b0);
    @(posedge clk_sys) sleep_mode <= 0;
    apb(0, `IDX_CTRL, 0); check("power awake", rdv[`CT_PWR], 1'b1);
    $display("test sleep done");
  endtask
  // false carrier events while the clock enable is low must not count
  task automatic t_freeze;
    @(posedge clk_sys) clk_en <= 0;
    rx_run(4'h8, 5);
    @(posedge clk_sys) clk_en <= 1;
    apb(0, `IDX_FCC, 0); check("fcc frozen", rdv, 32'h0);
    $display("test clock enable done");
  endtask
  // ==========================================
  // verdict and run control
  task automatic summarize;
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clk_sys);
    resetn <= 1;
    t_reset();
    t_false_carrier();
    t_rx_error();
    t_loopback_sel();
    t_line();
    t_prbs();
    t_sleep();
    t_freeze();
    summarize();
  end
  // watchdog, well beyond the few thousand cycles the tests need
  initial begin
    repeat (50000) @(posedge clk_sys);
    errors++;
    $display("[FAIL] watchdog expected finish seen hang");
    summarize();
  end
endmodule
